// ### pfc_feature_ctrl_regs.sv
// feature descriptor and control register bank with its byte-level command engine
//
// Summary of operation
// - feature bit 0 reports the taper and reads 1 for a linear element.
// - feature bit 1 reports volatility and reads 1 because settings are lost without power.
// - feature bits 3:2 give the element count minus one and read 00b.
// - feature bits 5:4 give the wiper positions per element and read 11b for 256.
// - feature bits 7:6 give the element resistance and read 11b for 100 kilohm.
// - the feature byte is a constant F3h returned by the control-register read command.
// - control bits 1:0 hold the selected wiper and steer later position commands.
// - control bits 3:2 must be the complement of bits 1:0 or the value is invalid.
// - control bit 6 drives the charge-pump enable output.
// - power-on reset clears the pump enable, selects wiper 00b and sets the complement to 11b.
// - only 0Ch and 4Ch are accepted as control values, every other byte is invalid.
// - an invalid control value leaves the control register and its pump and wiper outputs untouched.
// - after AAh the device sends the feature byte, then the control byte, then zeros.
// - after 55h the value is echoed and committed only on a correct release byte 96h.
// - an invalid received value is answered with FFh during the readback byte.
`timescale 1ns/1ps
`include "pfc_params.svh"

module pfc_feature_ctrl_regs
	import pfc_pkg::*;
#(
	parameter int WIPER_COUNT = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// byte port from the bus function controller
	input wire logic frameReset,
	input wire logic rxValid,
	input wire logic [7:0] rxData,
	input wire logic txReq,
	// answer byte to the bus function controller
	output logic txValid,
	output logic [7:0] txData,
	// register contents and device controls
	output logic [7:0] featureValue,
	output logic [7:0] ctrlValue,
	output logic [1:0] wiperSelect,
	output logic pumpEnable,
	output logic ctrlCommit
);
	import pfc_pkg::*;

	// refused at elaboration: the feature byte is wired for one element
	if (WIPER_COUNT != 1) begin : gBadCount
		$error("pfc_feature_ctrl_regs: only a single element is served");
	end

	// ****************************************
	// state and constants
	// ****************************************
	localparam pfc_regs_t REGS_RESET = '{
		state: PFC_IDLE,
		ctrl: `PFC_CTRL_RESET,
		pend: 8'h00,
		pendOk: 1'b0,
		failed: 1'b0,
		commit: 1'b0,
		txValid: 1'b0,
		txData: 8'h00
	};

	pfc_regs_t r_reg;
	pfc_regs_t r_next;
	logic rxOk;
	logic [7:0] feature;

	// hard-wired descriptor, never stored
	assign feature = {`PFC_FEAT_RESIST,
		`PFC_FEAT_POSITIONS,
		`PFC_FEAT_COUNT,
		`PFC_FEAT_VOLATILE,
		`PFC_FEAT_TAPER};

	pfc_ctrl_check #(
		.WIPER_COUNT(WIPER_COUNT)
	) u_check (
		.value(rxData),
		.valid(rxOk)
	);

	// ****************************************
	// command engine
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.txValid = 1'b0;
		r_next.commit = 1'b0;
		// reads with nothing to say see an idle high line
		if (txReq) begin
			r_next.txValid = 1'b1;
			r_next.txData = `PFC_ANSWER_ONES;
		end
		if (frameReset) begin
			// a reset pulse ends any command; a half-done write is dropped
			r_next.state = PFC_IDLE;
			r_next.txValid = 1'b0;
			r_next.pendOk = 1'b0;
			r_next.failed = 1'b0;
		end else begin
			case (r_reg.state)
				PFC_IDLE: begin
					if (rxValid) begin
						if (rxData == `PFC_CMD_READ_CTRL) begin
							r_next.state = PFC_RD_FEAT;
						end else if (rxData == `PFC_CMD_WRITE_CTRL) begin
							r_next.state = PFC_WR_VAL;
						end else begin
							r_next.state = PFC_SKIP;
						end
					end
				end
				PFC_RD_FEAT: begin
					if (txReq) begin
						r_next.txData = feature;
						r_next.state = PFC_RD_CTRL;
					end
				end
				PFC_RD_CTRL: begin
					if (txReq) begin
						r_next.txData = r_reg.ctrl;
						r_next.state = PFC_RD_ZERO;
					end
				end
				PFC_RD_ZERO: begin
					if (txReq) begin
						r_next.txData = `PFC_ANSWER_ZERO;
					end
				end
				PFC_WR_VAL: begin
					if (rxValid) begin
						r_next.pend = rxData;
						r_next.pendOk = rxOk;
						r_next.state = PFC_WR_ECHO;
					end
				end
				PFC_WR_ECHO: begin
					if (txReq) begin
						r_next.txData = r_reg.pendOk ? r_reg.pend : `PFC_ANSWER_ONES;
						r_next.state = PFC_WR_REL;
					end
				end
				PFC_WR_REL: begin
					if (rxValid) begin
						r_next.state = PFC_WR_DONE;
						// an invalid value is never committed, whatever release follows
						if (rxData == `PFC_RELEASE_CODE && r_reg.pendOk) begin
							r_next.ctrl = r_reg.pend;
							r_next.commit = 1'b1;
						end else begin
							r_next.failed = 1'b1;
						end
					end
				end
				PFC_WR_DONE: begin
					if (txReq) begin
						r_next.txData = r_reg.failed ? `PFC_ANSWER_ONES : `PFC_ANSWER_ZERO;
					end
				end
				PFC_SKIP: begin
					r_next.state = PFC_SKIP;
				end
				default: begin
					r_next.state = PFC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_reg <= REGS_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign txValid = r_reg.txValid;
	assign txData = r_reg.txData;
	assign featureValue = feature;
	assign ctrlValue = r_reg.ctrl;
	assign wiperSelect = r_reg.ctrl[`PFC_CTRL_WSEL_MSB:`PFC_CTRL_WSEL_LSB];
	assign pumpEnable = r_reg.ctrl[`PFC_CTRL_PUMP_BIT];
	assign ctrlCommit = r_reg.commit;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// plain signal so the hold check needs no sequence used as a value
	logic releaseHit;
	assign releaseHit = r_reg.state == PFC_WR_REL && rxValid && !frameReset
		&& rxData == `PFC_RELEASE_CODE && r_reg.pendOk;

	sequence sReleaseOk;
		releaseHit;
	endsequence

	sequence sReadFeature;
		r_reg.state == PFC_RD_FEAT && txReq && !frameReset;
	endsequence

	sequence sReadCtrl;
		r_reg.state == PFC_RD_CTRL && txReq && !frameReset;
	endsequence

	sequence sReadZero;
		r_reg.state == PFC_RD_ZERO && txReq && !frameReset;
	endsequence

	sequence sEchoInvalid;
		r_reg.state == PFC_WR_ECHO && txReq && !frameReset && !r_reg.pendOk;
	endsequence

	chk_feature_const: assert property (featureValue == 8'hf3)
		else $error("feature byte is not F3h");
	chk_reset_default: assert property ($fell(rst) |-> ctrlValue == 8'h0c)
		else $error("control byte not at default after reset");
	chk_ctrl_hold: assert property (!releaseHit |=> $stable(ctrlValue))
		else $error("control byte changed without a release");
	chk_ctrl_legal: assert property (ctrlValue == 8'h0c || ctrlValue == 8'h4c)
		else $error("control byte holds an invalid value");
	chk_wiper_pair: assert property (ctrlValue[3:2] == ~ctrlValue[1:0])
		else $error("wiper complement broken");
	chk_pump_output: assert property (pumpEnable == ctrlValue[6] && wiperSelect == ctrlValue[1:0])
		else $error("pump or wiper output disagrees with control byte");
	chk_read_order: assert property (sReadFeature |=> txValid && txData == 8'hf3)
		else $error("feature byte not sent first");
	chk_read_ctrl: assert property (sReadCtrl |=> txValid && txData == ctrlValue)
		else $error("control byte not sent second");
	chk_read_zero: assert property (sReadZero |=> txValid && txData == 8'h00)
		else $error("zero not sent after the two bytes");
	chk_echo_invalid: assert property (sEchoInvalid |=> txValid && txData == 8'hff)
		else $error("invalid value not answered with FFh");
	chk_commit_value: assert property (sReleaseOk |=> ctrlCommit && ctrlValue == $past(r_reg.pend))
		else $error("released value not committed");
endmodule

// ### pfc_params.svh
// constants for the potentiometer feature and control register bank
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

// ****************************************
// feature descriptor fields
// ****************************************
`define PFC_FEAT_TAPER 1'b1
`define PFC_FEAT_VOLATILE 1'b1
`define PFC_FEAT_COUNT 2'b00
`define PFC_FEAT_POSITIONS 2'b11
`define PFC_FEAT_RESIST 2'b11
`define PFC_FEATURE_VALUE 8'hf3

// ****************************************
// control register layout and values
// ****************************************
`define PFC_CTRL_WSEL_LSB 0
`define PFC_CTRL_WSEL_MSB 1
`define PFC_CTRL_WINV_LSB 2
`define PFC_CTRL_WINV_MSB 3
`define PFC_CTRL_PUMP_BIT 6
`define PFC_CTRL_RSVD_MASK 8'hb0
`define PFC_CTRL_RESET 8'h0c
`define PFC_CTRL_VALID_OFF 8'h0c
`define PFC_CTRL_VALID_ON 8'h4c

// ****************************************
// command and answer bytes
// ****************************************
`define PFC_CMD_READ_CTRL 8'haa
`define PFC_CMD_WRITE_CTRL 8'h55
`define PFC_RELEASE_CODE 8'h96
`define PFC_ANSWER_ONES 8'hff
`define PFC_ANSWER_ZERO 8'h00

`endif

// ### pfc_pkg.sv
// types for the potentiometer feature and control register bank
package pfc_pkg;

	typedef enum logic [8:0] {
		PFC_IDLE = 9'h001,
		PFC_RD_FEAT = 9'h002,
		PFC_RD_CTRL = 9'h004,
		PFC_RD_ZERO = 9'h008,
		PFC_WR_VAL = 9'h010,
		PFC_WR_ECHO = 9'h020,
		PFC_WR_REL = 9'h040,
		PFC_WR_DONE = 9'h080,
		PFC_SKIP = 9'h100
	} pfc_state_t;

	typedef struct packed {
		pfc_state_t state;
		logic [7:0] ctrl;
		logic [7:0] pend;
		logic pendOk;
		logic failed;
		logic commit;
		logic txValid;
		logic [7:0] txData;
	} pfc_regs_t;

endpackage

// ### pfc_ctrl_check.sv
// validity check of a received control byte
`timescale 1ns/1ps
`include "pfc_params.svh"

module pfc_ctrl_check #(
	parameter int WIPER_COUNT = 1
) (
	// byte under test
	input wire logic [7:0] value,
	// verdict
	output logic valid
);
	// refused at elaboration: the wiper field cannot address more than four elements
	if (WIPER_COUNT < 1 || WIPER_COUNT > 4) begin : gBadCount
		$error("pfc_ctrl_check: WIPER_COUNT must be 1 to 4");
	end

	logic [1:0] wsel;
	logic [1:0] winv;
	logic [2:0] wselWide;
	logic [2:0] countWide;

	assign wsel = value[`PFC_CTRL_WSEL_MSB:`PFC_CTRL_WSEL_LSB];
	assign winv = value[`PFC_CTRL_WINV_MSB:`PFC_CTRL_WINV_LSB];
	assign wselWide = {1'b0, wsel};
	assign countWide = 3'(WIPER_COUNT);

	// reserved bits must be zero, complement must pair, wiper must exist
	assign valid = ((value & `PFC_CTRL_RSVD_MASK) == 8'h00)
		&& (winv == ~wsel)
		&& (wselWide < countWide);
endmodule

// ### pfc_bus_master_model.sv
// bus master model driving the byte port of the register bank
`timescale 1ns/1ps
module pfc_bus_master_model (
	input wire logic clk,
	output logic frameReset,
	output logic rxValid,
	output logic [7:0] rxData,
	output logic txReq,
	input wire logic txValid,
	input wire logic [7:0] txData
);
	initial begin
		frameReset = 1'b0;
		rxValid = 1'b0;
		rxData = 8'h00;
		txReq = 1'b0;
	end
	task automatic busReset();
		@(negedge clk) frameReset = 1'b1;
		@(negedge clk) frameReset = 1'b0;
	endtask
	// released data shows the inverse so a stale byte never looks fresh
	task automatic sendByte(input logic [7:0] x);
		@(negedge clk);
		rxValid = 1'b1;
		rxData = x;
		@(negedge clk);
		rxValid = 1'b0;
		rxData = ~x;
	endtask
	task automatic readByte(output logic [7:0] x, output logic got);
		@(negedge clk) txReq = 1'b1;
		// the answer stands for the one cycle after the request edge
		@(negedge clk);
		got = txValid;
		x = txData;
		txReq = 1'b0;
	endtask
	task automatic writeCtrl(input logic [7:0] v, input logic [7:0] rel,
		output logic [7:0] echo, output logic [7:0] after);
		logic got;
		busReset();
		sendByte(8'h55);
		sendByte(v);
		readByte(echo, got);
		// an all-ones readback means the value was refused
		if (echo === v && echo !== 8'hff) begin
			sendByte(rel);
			readByte(after, got);
		end else begin
			after = echo;
			busReset();
		end
	endtask
endmodule

// ### pfc_feature_ctrl_regs_tb.sv
// self-checking testbench of the feature and control register bank
`timescale 1ns/1ps
module pfc_feature_ctrl_regs_tb;
	logic clk, rst, frameReset, rxValid, txReq, txValid, pumpEnable, ctrlCommit, got;
	logic [7:0] rxData, txData, featureValue, ctrlValue, echo, after, b, cur;
	logic [1:0] wiperSelect;
	logic [7:0] bad [8] = '{8'h0d, 8'h4d, 8'hcc, 8'h1c, 8'h00, 8'hff, 8'h48, 8'h0f};
	int seed = 32'h5fd3;
	int miscompares = 0;
	int compares = 0;
	int commits = 0;
	int expCommits = 0;

	pfc_feature_ctrl_regs dut_u (.clk(clk), .rst(rst), .frameReset(frameReset),
		.rxValid(rxValid), .rxData(rxData), .txReq(txReq), .txValid(txValid),
		.txData(txData), .featureValue(featureValue), .ctrlValue(ctrlValue),
		.wiperSelect(wiperSelect), .pumpEnable(pumpEnable), .ctrlCommit(ctrlCommit));
	pfc_bus_master_model mst_u (.clk(clk), .frameReset(frameReset), .rxValid(rxValid),
		.rxData(rxData), .txReq(txReq), .txValid(txValid), .txData(txData));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(negedge clk) if (ctrlCommit === 1'b1) commits++;

	task automatic complete_run();
		if (miscompares == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic ctrlOk(input logic [7:0] x);
		return x == 8'h0c || x == 8'h4c;
	endfunction
	function automatic logic [7:0] expEcho(input logic [7:0] x);
		return ctrlOk(x) ? x : 8'hff;
	endfunction

	// ********
	// sequences
	// ********
	task automatic doWrite(input logic [7:0] x, input logic [7:0] rel);
		mst_u.writeCtrl(x, rel, echo, after);
		chk(echo, expEcho(x));
		if (ctrlOk(x)) begin
			chk(after, (rel == 8'h96) ? 8'h00 : 8'hff);
			if (rel == 8'h96) begin
				cur = x;
				expCommits++;
			end
		end
		chk(ctrlValue, cur);
		chk({7'h0, pumpEnable}, {7'h0, cur[6]});
		chk({6'h0, wiperSelect}, {6'h0, cur[1:0]});
		chk(8'(commits), 8'(expCommits));
	endtask
	task automatic readRegs();
		mst_u.busReset();
		mst_u.sendByte(8'haa);
		mst_u.readByte(b, got);
		chk({7'h0, got}, 8'h01);
		chk(b, 8'hf3);
		mst_u.readByte(b, got);
		chk(b, cur);
		mst_u.readByte(b, got);
		chk(b, 8'h00);
	endtask

	initial begin
		rst = 1'b1;
		cur = 8'h0c;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		chk(ctrlValue, 8'h0c);
		chk({7'h0, featureValue[0]}, 8'h01);
		chk({7'h0, featureValue[1]}, 8'h01);
		chk({6'h0, featureValue[3:2]}, 8'h00);
		chk({6'h0, featureValue[5:4]}, 8'h03);
		chk({6'h0, featureValue[7:6]}, 8'h03);
		readRegs();
		doWrite(8'h4c, 8'h96);
		readRegs();
		doWrite(8'h0c, 8'h69);
		foreach (bad[i]) doWrite(bad[i], 8'h96);
		repeat (16) doWrite(8'($random(seed)), 8'h96);
		doWrite(8'h0c, 8'h96);
		// a bus reset between readback and release drops the pending value
		mst_u.busReset();
		mst_u.sendByte(8'h55);
		mst_u.sendByte(8'h4c);
		mst_u.readByte(b, got);
		chk(b, 8'h4c);
		mst_u.busReset();
		mst_u.sendByte(8'h96);
		chk(ctrlValue, cur);
		mst_u.busReset();
		mst_u.sendByte(8'h33);
		mst_u.readByte(b, got);
		chk(b, 8'hff);
		chk(ctrlValue, cur);
		doWrite(8'h4c, 8'h96);
		@(negedge clk) rst = 1'b1;
		@(negedge clk) rst = 1'b0;
		cur = 8'h0c;
		chk(ctrlValue, 8'h0c);
		chk({7'h0, pumpEnable}, 8'h00);
		readRegs();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("[ERR] %0t run did not finish", $time);
		complete_run();
	end
endmodule
